/* File: pwm_mode_pkg.sv */
// constants and types for the pwm and channel mode control block
package pwm_mode_pkg;
  localparam int CLK_MHZ      = 200;
  localparam int MIN_PULSE_NS = 1000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [19:0] MIN_PULSE_W = 20'(MIN_PULSE_CYC);
  localparam int TICK_SHIFT   = 5;
  localparam int PERIOD_SHIFT = 12;
  localparam int DUTY_BITS = 7;
  localparam int RATE_BITS = 5;
  localparam int ADC_BITS  = 8;
  localparam int DAC_BITS  = 8;
  localparam int NCH       = 2;
  localparam logic [6:0] DUTY_OFF   = 7'h00;
  localparam logic [6:0] DUTY_FULL  = 7'h7F;
  localparam logic [6:0] PHASE_LAST = 7'h7F;
  localparam logic [4:0] RATE_OFF   = 5'h00;
  // clock multiple of the fastest period, per rate select
  localparam logic [7:0] RATE_MULT [0:31] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h10,
    8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h50,
    8'h58, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88, 8'h90,
    8'h98, 8'hA0, 8'hA8, 8'hB0, 8'hB8, 8'hC0, 8'hC8, 8'hE0};
  localparam logic [7:0] RATE_LIMIT_OFF = 8'h00;
  localparam logic [7:0] COMMON_CFG_OFF = 8'h04;
  localparam logic [7:0] CH0_CFG_OFF    = 8'h08;
  localparam logic [7:0] CH1_CFG_OFF    = 8'h0C;
  localparam logic [7:0] CTRL_CFG_OFF   = 8'h10;
  localparam logic [7:0] STATUS_OFF     = 8'h14;
  localparam int RATE_LSB   = 0;
  localparam int MINOUT_LSB = 9;
  localparam int INTREF_BIT = 0;
  localparam int PDN_LSB    = 1;
  localparam logic [31:0] RATE_LIMIT_RST = 32'h0000_0000;
  localparam logic [31:0] COMMON_CFG_RST = 32'h0000_001E;
  localparam logic [31:0] CH_CFG_RST     = 32'h0000_0010;
  localparam logic [31:0] CTRL_CFG_RST   = 32'h0000_0003;
  localparam logic [15:0] CTRL_STOP_CODE = 16'h0004;
  localparam logic [1:0]  PDN_UP         = 2'h0;
  localparam logic [2:0] GAIN_EXT = 3'h0;
  localparam logic [2:0] GAIN_1X  = 3'h1;
  localparam logic [2:0] GAIN_1P5 = 3'h2;
  localparam logic [2:0] GAIN_4X  = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {REF_SUPPLY, REF_INTERNAL, REF_EXTERNAL} ref_type;
  typedef struct packed {
    logic [2:0] gain;
    logic       hiz_dis;
    logic       inv;
    logic       od;
    logic       cmp_en;
  } chan_cfg_type;
  typedef struct packed {
    ref_type    refsel;
    logic [2:0] gain;
    logic       open_loop;
    logic       input_highz;
    logic       powered;
  } chan_ctl_type;
endpackage

/* File: pwm_mode_ctrl.sv */
// pwm generator, channel mode control and adc code conversion
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - pwm drives the shared pin only while the mode pin is high
// - codes 1 to 126 give high time of code over 128 of period
// - code 0 holds output low, code 127 holds it high
// - duty code comes only from the controller, never from software
// - five-bit rate select sets pwm frequency; zero is invalid
// - duty resolution depends on rate; short pulses clamp to one microsecond
// - comparator enable makes channel a comparator with open-loop amplifier
// - open-drain bit selects push-pull or open-drain comparator output
// - invert bit inverts comparator output polarity
// - analog input defaults high impedance; disable bit selects finite impedance
// - internal reference off after reset, enabled by its config bit
// - supply rail is default reference with unity gain
// - with internal reference gain selects 1.5, 2, 3 or 4
// - one gain encoding selects the external reference
// - power-up code in the power-down field enables voltage output
// - adc code is truncated input over full scale, saturated at maximum
// - output converter code is N bits, zero to full code
module pwm_mode_ctrl (
  // clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RST,
  // axi4-lite register port
  input  wire logic [7:0]                     AWADDR,
  input  wire logic                           AWVALID,
  output logic                                AWREADY,
  input  wire logic [31:0]                    WDATA,
  input  wire logic [3:0]                     WSTRB,
  input  wire logic                           WVALID,
  output logic                                WREADY,
  output logic [1:0]                          BRESP,
  output logic                                BVALID,
  input  wire logic                           BREADY,
  input  wire logic [7:0]                     ARADDR,
  input  wire logic                           ARVALID,
  output logic                                ARREADY,
  output logic [31:0]                         RDATA,
  output logic [1:0]                          RRESP,
  output logic                                RVALID,
  input  wire logic                           RREADY,
  // pwm pin, open drain
  input  wire logic                           MODE,
  output logic                                PWM_O,
  output logic                                PWM_OE,
  // controller side
  input  wire logic [6:0]                     DUTY_CODE,
  input  wire logic [7:0]                     DAC_DATA,
  output logic [7:0]                          DAC_CODE,
  output logic [6:0]                          MIN_OUTPUT,
  output logic [15:0]                         CTRL_CONFIG,
  output logic                                CTRL_HALT,
  // adc conversion
  input  wire logic [15:0]                    ADC_VIN,
  input  wire logic [15:0]                    ADC_VFS,
  output logic [7:0]                          ADC_CODE,
  // comparator channels
  input  wire logic [1:0]                     CMP_RAW,
  output logic [1:0]                          CMP_O,
  output logic [1:0]                          CMP_OE,
  output pwm_mode_pkg::chan_ctl_type [1:0]    CHAN_CTL
);
  logic [31:0] rate_limit_r, common_cfg_r, ctrl_cfg_r;
  pwm_mode_pkg::chan_cfg_type [1:0] ch_cfg_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_word;
  logic        wr_do, rd_hit;
  logic [4:0]  rate_r;
  logic [6:0]  code_r, phase_r;
  logic [12:0] div_r, tick_len;
  logic [19:0] cyc_r, period_len, hi_len_r;
  logic        tick, bound, pwm_lvl_r, lvl_nxt;
  logic [7:0]  adc_code_r, adc_nxt, dac_code_r;
  logic [23:0] adc_quot;
  logic [1:0]  cmp_res_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // write path: address and data taken in either order, answer follows both
  assign AWREADY = !aw_full_r && !bvalid_r;
  assign WREADY  = !w_full_r && !bvalid_r;
  assign wr_do   = aw_full_r && w_full_r && !bvalid_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= AWADDR;
    end else if (wr_do) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (WVALID && WREADY) begin
      w_full_r <= 1'b1;
      w_data_r <= WDATA;
      w_strb_r <= WSTRB;
    end else if (wr_do) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= pwm_mode_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      unique case (aw_addr_r)
        pwm_mode_pkg::RATE_LIMIT_OFF, pwm_mode_pkg::COMMON_CFG_OFF,
        pwm_mode_pkg::CH0_CFG_OFF, pwm_mode_pkg::CH1_CFG_OFF,
        pwm_mode_pkg::CTRL_CFG_OFF: bresp_r <= pwm_mode_pkg::RESP_OKAY;
        default: bresp_r <= pwm_mode_pkg::RESP_SLVERR;
      endcase
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // register file; no field here reaches the duty code
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rate_limit_r <= pwm_mode_pkg::RATE_LIMIT_RST;
      common_cfg_r <= pwm_mode_pkg::COMMON_CFG_RST;
      ctrl_cfg_r   <= pwm_mode_pkg::CTRL_CFG_RST;
      ch_cfg_r     <= {2{pwm_mode_pkg::CH_CFG_RST[6:0]}};
    end else if (wr_do) begin
      unique case (aw_addr_r)
        // rate and limit share one word, so one write carries both
        pwm_mode_pkg::RATE_LIMIT_OFF:
          rate_limit_r <= merge(rate_limit_r, w_data_r, w_strb_r);
        pwm_mode_pkg::COMMON_CFG_OFF: common_cfg_r <= merge(common_cfg_r, w_data_r, w_strb_r);
        pwm_mode_pkg::CTRL_CFG_OFF:   ctrl_cfg_r   <= merge(ctrl_cfg_r, w_data_r, w_strb_r);
        pwm_mode_pkg::CH0_CFG_OFF:    ch_cfg_r[0]  <= w_strb_r[0] ? w_data_r[6:0] : ch_cfg_r[0];
        pwm_mode_pkg::CH1_CFG_OFF:    ch_cfg_r[1]  <= w_strb_r[0] ? w_data_r[6:0] : ch_cfg_r[1];
        default: ;
      endcase
    end
  end

  // read path
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (ARADDR)
      pwm_mode_pkg::RATE_LIMIT_OFF: rd_word = rate_limit_r;
      pwm_mode_pkg::COMMON_CFG_OFF: rd_word = common_cfg_r;
      pwm_mode_pkg::CH0_CFG_OFF:    rd_word = {25'h0, ch_cfg_r[0]};
      pwm_mode_pkg::CH1_CFG_OFF:    rd_word = {25'h0, ch_cfg_r[1]};
      pwm_mode_pkg::CTRL_CFG_OFF:   rd_word = ctrl_cfg_r;
      pwm_mode_pkg::STATUS_OFF:     rd_word = {16'h0, cmp_res_r, pwm_lvl_r, MODE, code_r, rate_r};
      default:                      rd_hit  = 1'b0;
    endcase
  end

  assign ARREADY = !rvalid_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= pwm_mode_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? pwm_mode_pkg::RESP_OKAY : pwm_mode_pkg::RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // controller hand-off
  assign MIN_OUTPUT  = rate_limit_r[pwm_mode_pkg::MINOUT_LSB +: 7];
  assign CTRL_CONFIG = ctrl_cfg_r[15:0];
  assign CTRL_HALT   = (ctrl_cfg_r[15:0] == pwm_mode_pkg::CTRL_STOP_CODE);

  // pwm timebase: tick enable every mult*32 clocks, 128 ticks a period
  assign tick_len   = 13'(pwm_mode_pkg::RATE_MULT[rate_r]) << pwm_mode_pkg::TICK_SHIFT;
  assign period_len = 20'(pwm_mode_pkg::RATE_MULT[rate_r]) << pwm_mode_pkg::PERIOD_SHIFT;
  assign tick  = (div_r == tick_len - 13'h0001);
  assign bound = tick && (phase_r == pwm_mode_pkg::PHASE_LAST);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_r   <= 13'h0000;
      phase_r <= 7'h00;
      cyc_r   <= 20'h00000;
      rate_r  <= pwm_mode_pkg::RATE_OFF;
      code_r  <= pwm_mode_pkg::DUTY_OFF;
    end else if (rate_r == pwm_mode_pkg::RATE_OFF || bound) begin
      // duty and rate change only between periods, so no runt pulse
      div_r   <= 13'h0000;
      phase_r <= 7'h00;
      cyc_r   <= 20'h00000;
      rate_r  <= rate_limit_r[pwm_mode_pkg::RATE_LSB +: 5];
      code_r  <= DUTY_CODE;
    end else begin
      cyc_r <= cyc_r + 20'h00001;
      if (tick) begin
        div_r   <= 13'h0000;
        phase_r <= phase_r + 7'h01;
      end else begin
        div_r <= div_r + 13'h0001;
      end
    end
  end

  always_comb begin
    if (rate_r == pwm_mode_pkg::RATE_OFF) begin
      lvl_nxt = 1'b0;
    end else if (code_r == pwm_mode_pkg::DUTY_OFF) begin
      lvl_nxt = 1'b0;
    end else if (code_r == pwm_mode_pkg::DUTY_FULL) begin
      lvl_nxt = 1'b1;
    end else begin
      // fast rates cannot make pulses shorter than the minimum, high or low
      lvl_nxt = ((phase_r < code_r) || (cyc_r < pwm_mode_pkg::MIN_PULSE_W))
                && (cyc_r < period_len - pwm_mode_pkg::MIN_PULSE_W);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwm_lvl_r <= 1'b0;
    end else begin
      pwm_lvl_r <= lvl_nxt;
    end
  end

  // pin released for high, pulled low otherwise; nothing driven in programming mode
  assign PWM_O  = 1'b0;
  assign PWM_OE = MODE && !pwm_lvl_r;

  // adc code conversion, saturating
  assign adc_quot = (ADC_VFS == 16'h0000) ? 24'hFFFFFF : ({ADC_VIN, 8'h00} / {8'h00, ADC_VFS});
  assign adc_nxt  = (adc_quot > 24'h0000FF) ? 8'hFF : adc_quot[7:0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      adc_code_r <= 8'h00;
      dac_code_r <= 8'h00;
    end else begin
      adc_code_r <= adc_nxt;
      dac_code_r <= DAC_DATA;
    end
  end

  assign ADC_CODE = adc_code_r;
  assign DAC_CODE = dac_code_r;

  // comparator channels and analog mode controls
  for (genvar ch = 0; ch < pwm_mode_pkg::NCH; ch++) begin : g_ch
    logic [1:0] pdn;
    assign pdn = common_cfg_r[pwm_mode_pkg::PDN_LSB + 2*ch +: 2];

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        cmp_res_r[ch] <= 1'b0;
      end else begin
        cmp_res_r[ch] <= ch_cfg_r[ch].cmp_en && (CMP_RAW[ch] ^ ch_cfg_r[ch].inv);
      end
    end

    assign CMP_O[ch]  = cmp_res_r[ch] && !ch_cfg_r[ch].od;
    assign CMP_OE[ch] = ch_cfg_r[ch].cmp_en && (!ch_cfg_r[ch].od || !cmp_res_r[ch]);

    always_comb begin
      CHAN_CTL[ch].open_loop   = ch_cfg_r[ch].cmp_en;
      CHAN_CTL[ch].input_highz = !ch_cfg_r[ch].hiz_dis;
      CHAN_CTL[ch].powered     = (pdn == pwm_mode_pkg::PDN_UP);
      if (ch_cfg_r[ch].gain == pwm_mode_pkg::GAIN_EXT) begin
        CHAN_CTL[ch].refsel = pwm_mode_pkg::REF_EXTERNAL;
        CHAN_CTL[ch].gain   = pwm_mode_pkg::GAIN_1X;
      end else if (common_cfg_r[pwm_mode_pkg::INTREF_BIT]
                   && ch_cfg_r[ch].gain >= pwm_mode_pkg::GAIN_1P5
                   && ch_cfg_r[ch].gain <= pwm_mode_pkg::GAIN_4X) begin
        CHAN_CTL[ch].refsel = pwm_mode_pkg::REF_INTERNAL;
        CHAN_CTL[ch].gain   = ch_cfg_r[ch].gain;
      end else begin
        CHAN_CTL[ch].refsel = pwm_mode_pkg::REF_SUPPLY;
        CHAN_CTL[ch].gain   = pwm_mode_pkg::GAIN_1X;
      end
    end

    property p_cmp_inv;
      @(posedge CLK) disable iff (RST)
      ch_cfg_r[ch].cmp_en && !ch_cfg_r[ch].od && $stable(ch_cfg_r[ch])
        |=> CMP_O[ch] == (($past(CMP_RAW[ch]) ^ $past(ch_cfg_r[ch].inv)) && !ch_cfg_r[ch].od);
    endproperty
    a_cmp_inv: assert property (p_cmp_inv) else $error("comparator polarity wrong");

    property p_cmp_od;
      @(posedge CLK) disable iff (RST)
      ch_cfg_r[ch].od |-> !CMP_O[ch] && !(CMP_OE[ch] && cmp_res_r[ch]);
    endproperty
    a_cmp_od: assert property (p_cmp_od) else $error("open drain drives high");

    property p_ref_gain;
      @(posedge CLK) disable iff (RST)
      CHAN_CTL[ch].refsel != pwm_mode_pkg::REF_INTERNAL
        |-> CHAN_CTL[ch].gain == pwm_mode_pkg::GAIN_1X;
    endproperty
    a_ref_gain: assert property (p_ref_gain) else $error("gain not unity");

    property p_intref;
      @(posedge CLK) disable iff (RST)
      CHAN_CTL[ch].refsel == pwm_mode_pkg::REF_INTERNAL
        |-> common_cfg_r[pwm_mode_pkg::INTREF_BIT];
    endproperty
    a_intref: assert property (p_intref) else $error("internal ref used while off");
  end

  // helper: length of the current high run
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hi_len_r <= 20'h00000;
    end else if (!pwm_lvl_r) begin
      hi_len_r <= 20'h00000;
    end else if (hi_len_r != 20'hFFFFF) begin
      hi_len_r <= hi_len_r + 20'h00001;
    end
  end

  property p_mode_off;
    @(posedge CLK) disable iff (RST)
    !MODE |-> !PWM_OE;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("pwm driven in program mode");

  property p_code_zero;
    @(posedge CLK) disable iff (RST)
    rate_r != pwm_mode_pkg::RATE_OFF && code_r == pwm_mode_pkg::DUTY_OFF |=> !pwm_lvl_r;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code zero not low");

  property p_code_full;
    @(posedge CLK) disable iff (RST)
    rate_r != pwm_mode_pkg::RATE_OFF && code_r == pwm_mode_pkg::DUTY_FULL |=> pwm_lvl_r;
  endproperty
  a_code_full: assert property (p_code_full) else $error("full code not high");

  property p_rate_off;
    @(posedge CLK) disable iff (RST)
    rate_r == pwm_mode_pkg::RATE_OFF |=> !pwm_lvl_r;
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("pwm runs at invalid rate");

  property p_duty_hold;
    @(posedge CLK) disable iff (RST)
    rate_r != pwm_mode_pkg::RATE_OFF && !bound |=> $stable(code_r) && $stable(rate_r);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed mid period");

  property p_min_high;
    @(posedge CLK) disable iff (RST)
    $fell(pwm_lvl_r) |-> $past(hi_len_r) >= pwm_mode_pkg::MIN_PULSE_W - 20'h00001;
  endproperty
  a_min_high: assert property (p_min_high) else $error("high pulse too short");

  property p_adc_sat;
    @(posedge CLK) disable iff (RST)
    ADC_VIN >= ADC_VFS |=> ADC_CODE == 8'hFF;
  endproperty
  a_adc_sat: assert property (p_adc_sat) else $error("adc code not saturated");

  property p_bresp_hold;
    @(posedge CLK) disable iff (RST)
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
endmodule
`default_nettype wire

/* File: pwm_load_model.sv */
// power stage model on the pulled-up pwm pin, counts high and driven cycles
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
  // pin side
  input  wire logic clk,
  input  wire logic pwm_o,
  input  wire logic pwm_oe,
  // measurement window, counters clear while low
  input  wire logic meas,
  output logic      pin,
  output int        hi_cnt,
  output int        oe_cnt
);
  // pull-up: released pin reads high
  assign pin = pwm_oe ? pwm_o : 1'b1;
  always_ff @(posedge clk) begin
    if (!meas) begin
      hi_cnt <= 0;
      oe_cnt <= 0;
    end else begin
      hi_cnt <= hi_cnt + int'(pin);
      oe_cnt <= oe_cnt + int'(pwm_oe);
    end
  end
endmodule
`default_nettype wire

/* File: pwm_and_channel_mode_control_tb_top.sv */
// self-checking bench for the pwm and channel mode control block
`timescale 1ns/100ps
`default_nettype none
module pwm_and_channel_mode_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, mode = 1'b0, meas = 1'b0, pin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dac_data = 8'h00, dac_code, adc_code;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ctrl_halt;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, cmp_o, cmp_oe, cmp_raw = 2'h0;
  logic [6:0] duty_code = 7'h00, min_output;
  logic [15:0] ctrl_config, adc_vin = 16'h0000, adc_vfs = 16'h0001;
  logic pwm_o, pwm_oe;
  pwm_mode_pkg::chan_ctl_type [1:0] chan_ctl;
  int hi_cnt, oe_cnt;
  int n_mismatch = 0;
  int num_checks = 0;
  pwm_mode_ctrl dut_u (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .MODE(mode), .PWM_O(pwm_o), .PWM_OE(pwm_oe), .DUTY_CODE(duty_code),
    .DAC_DATA(dac_data), .DAC_CODE(dac_code), .MIN_OUTPUT(min_output),
    .CTRL_CONFIG(ctrl_config), .CTRL_HALT(ctrl_halt), .ADC_VIN(adc_vin), .ADC_VFS(adc_vfs),
    .ADC_CODE(adc_code), .CMP_RAW(cmp_raw), .CMP_O(cmp_o), .CMP_OE(cmp_oe),
    .CHAN_CTL(chan_ctl));
  pwm_load_model load_u (.clk(clk), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .meas(meas),
    .pin(pin), .hi_cnt(hi_cnt), .oe_cnt(oe_cnt));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is sampled at the falling edge: inputs only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ap, wp, at, wt, b;
    int t;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ap = 1; wp = 1; b = 0; t = 0;
    while (!b && t < 64) begin
      @(negedge clk);
      at = ap && awready; wt = wp && wready; b = bvalid; r = bresp;
      @(posedge clk);
      if (at) begin awvalid <= 1'b0; ap = 0; end
      if (wt) begin wvalid <= 1'b0; wp = 0; end
      t++;
    end
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit at, b;
    int t;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    b = 0; t = 0;
    while (!b && t < 64) begin
      @(negedge clk);
      at = arvalid && arready; b = rvalid;
      if (b) chk("rdata", ed, rdata);
      if (b) chk("rresp", 32'(er), 32'(rresp));
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      t++;
    end
    rready <= 1'b0;
    if (!b) chk("rvalid", 32'h1, 32'h0);
  endtask
  function automatic int hi_exp(input int code, input int per);
    int h;
    if (code == 0) return 0;
    if (code == 127) return per;
    h = code * per / 128;
    if (h < pwm_mode_pkg::MIN_PULSE_CYC) h = pwm_mode_pkg::MIN_PULSE_CYC;
    if (h > per - pwm_mode_pkg::MIN_PULSE_CYC) h = per - pwm_mode_pkg::MIN_PULSE_CYC;
    return h;
  endfunction
  // settle must cover one full old period so the new code is in force
  task automatic pwm_chk(input logic [6:0] c, input logic m, input int per, input int st,
                         input int eh);
    @(posedge clk);
    duty_code <= c; mode <= m;
    repeat (st) @(posedge clk);
    meas <= 1'b1;
    repeat (per) @(posedge clk);
    meas <= 1'b0;
    @(negedge clk);
    chk("pin high", 32'(m ? eh : per), 32'(hi_cnt));
    chk("pin driven", 32'(m ? per - eh : 0), 32'(oe_cnt));
  endtask
  task automatic cmp_step(input logic [1:0] raw, input logic [1:0] eo, input logic [1:0] eoe);
    @(posedge clk);
    cmp_raw <= raw;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("cmp out", 32'(eo), 32'(cmp_o));
    chk("cmp oe", 32'(eoe), 32'(cmp_oe));
  endtask
  task automatic conv(input logic [15:0] vi, input logic [15:0] vf, input logic [7:0] e);
    @(posedge clk);
    adc_vin <= vi; adc_vfs <= vf; dac_data <= ~e;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("adc code", 32'(e), 32'(adc_code));
    chk("dac code", {24'h0, ~e}, 32'(dac_code));
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 32'h0000001E, 2'h0);
    rd(8'h08, 32'h00000010, 2'h0);
    rd(8'h00, 32'h00000000, 2'h0);
    rd(8'h10, 32'h00000003, 2'h0);
    rd(8'h20, 32'h00000000, 2'h2);
    wr(8'h14, 32'h00000FE0, 2'h2);
    chk("ch0 ctl", {24'h0, pwm_mode_pkg::REF_SUPPLY, 6'h0A}, 32'(chan_ctl[0]));
    pwm_chk(7'h40, 1'b1, 4096, 16, 0);
    wr(8'h00, 32'h00000A01, 2'h0);
    chk("min out", 32'h5, 32'(min_output));
    pwm_chk(7'h00, 1'b1, 4096, 4104, 0);
    pwm_chk(7'h7F, 1'b1, 4096, 4104, 4096);
    rd(8'h14, 32'h00003FE1, 2'h0);
    pwm_chk(7'h40, 1'b1, 4096, 4104, hi_exp(64, 4096));
    pwm_chk(7'h01, 1'b1, 4096, 4104, hi_exp(1, 4096));
    pwm_chk(7'h7E, 1'b1, 4096, 4104, hi_exp(126, 4096));
    pwm_chk(7'h40, 1'b0, 4096, 4104, 0);
    wr(8'h00, 32'h00000A02, 2'h0);
    pwm_chk(7'h40, 1'b1, 8192, 12296, hi_exp(64, 8192));
    wr(8'h08, 32'h0000001D, 2'h0);
    chk("open loop", 32'h1, 32'(chan_ctl[0].open_loop));
    chk("input hiz", 32'h0, 32'(chan_ctl[0].input_highz));
    cmp_step(2'h0, 2'h1, 2'h1);
    cmp_step(2'h1, 2'h0, 2'h1);
    wr(8'h08, 32'h0000001F, 2'h0);
    cmp_step(2'h0, 2'h0, 2'h0);
    cmp_step(2'h1, 2'h0, 2'h1);
    wr(8'h04, 32'h00000019, 2'h0);
    wr(8'h08, 32'h00000020, 2'h0);
    chk("int ref", {27'h0, pwm_mode_pkg::REF_INTERNAL, 3'h2}, 32'(chan_ctl[0][7:3]));
    chk("ch0 up", 32'h1, 32'(chan_ctl[0].powered));
    chk("ch1 down", 32'h0, 32'(chan_ctl[1].powered));
    wr(8'h08, 32'h00000000, 2'h0);
    chk("ext ref", 32'(pwm_mode_pkg::REF_EXTERNAL), 32'(chan_ctl[0].refsel));
    wr(8'h04, 32'h00000018, 2'h0);
    wr(8'h08, 32'h00000020, 2'h0);
    chk("sup ref", {27'h0, pwm_mode_pkg::REF_SUPPLY, 3'h1}, 32'(chan_ctl[0][7:3]));
    conv(16'h0064, 16'h00C8, 8'h80);
    conv(16'h00C7, 16'h00C8, 8'hFE);
    conv(16'h012C, 16'h00C8, 8'hFF);
    conv(16'h0010, 16'h0000, 8'hFF);
    wr(8'h10, 32'h00000004, 2'h0);
    chk("halt", 32'h1, 32'(ctrl_halt));
    chk("ctrl cfg", 32'h4, 32'(ctrl_config));
    wr(8'h10, 32'h00000003, 2'h0);
    chk("run", 32'h0, 32'(ctrl_halt));
    print_verdict();
  end
endmodule
`default_nettype wire
